//--- hdl/iec_params.svh
// Offsets, field positions, reset values and timing counts of the encoder counter.
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IEC_OFF_OUT_LO   8'h00
`define IEC_OFF_OUT_HI   8'h04
`define IEC_OFF_IN_LO    8'h08
`define IEC_OFF_IN_HI    8'h0C
`define IEC_OFF_FEATURE  8'h10
`define IEC_OFF_STATUS   8'h14
// ----------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------
`define IEC_CTL_ZP_LATCH_EN  0
`define IEC_CTL_EXT_LATCH_EN 1
`define IEC_CTL_SET_COUNTER  2
// ----------------------------------------------------------------
// Feature fields and reset value
// ----------------------------------------------------------------
`define IEC_FEA_MODE_LSB  0
`define IEC_FEA_EVAL_LSB  2
`define IEC_FEA_COMPL     4
`define IEC_FEATURE_RST   5'h18
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define IEC_ST_LATCH_VALID  0
`define IEC_ST_OVERFLOW     1
`define IEC_ST_UNDERFLOW    2
`define IEC_ST_PERIOD_VALID 3
`define IEC_ST_ALARM        4
`define IEC_ST_GATE         5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IEC_CLK_NS         20
`define IEC_PERIOD_RES_NS  200
`define IEC_PERIOD_TICK_CYC (`IEC_PERIOD_RES_NS / `IEC_CLK_NS)
`define IEC_RUN_TIMEOUT_MS 100
`define IEC_RUN_TIMEOUT_CYC (`IEC_RUN_TIMEOUT_MS * 1000000 / `IEC_CLK_NS)
`endif

//--- hdl/iec_pkg.sv
// Types shared by the encoder counter design.
package iec_pkg;
  // Operating mode selected by the feature register.
  typedef enum logic [1:0] {
    IEC_MODE_ENCODER = 2'h0,
    IEC_MODE_UPDOWN  = 2'h1,
    IEC_MODE_PERIOD  = 2'h2
  } iec_mode_t;
  // Edge evaluation of the quadrature tracks.
  typedef enum logic [1:0] {
    IEC_EVAL_X1 = 2'h0,
    IEC_EVAL_X2 = 2'h1,
    IEC_EVAL_X4 = 2'h2
  } iec_eval_t;
endpackage

//--- hdl/iec_counter.sv
// Incremental encoder counter with latch, period measurement and APB registers.
//
// Behaviour
// - 16-bit position counter from quadrature decoder, 16-bit latch; read, preset, arm latch.
// - Decoder offers 1, 2 or 4-fold evaluation, single-ended or complementary tracks.
// - Reset default is 4-fold complementary incremental encoder mode.
// - Feature setting picks encoder mode or up/down counter mode.
// - Up/down mode steps counter on each rising edge of track A.
// - Up/down mode: track B low counts up, high counts down.
// - Up/down mode: index track low enables counting, high holds it.
// - Gate input high suppresses all counting.
// - Index pulse captures counter into latch when zero-pulse latch enable set, except in up/down mode.
// - Rising external latch input captures counter when external latch enable set.
// - Period mode measures time between rising edges of A at 200 ns resolution.
// - Counter overflow and underflow are reported to the host.
// - Process image is 6 bytes in, 6 bytes out, control/status byte lowest.
// - Counter word in bytes COUNTER_WORD_BYTES read and preset; latch word in LATCH_WORD_BYTES read only.
// - Period mode returns period in byte D2 plus bytes LATCH_WORD_BYTES.
// - Run indicator shows data exchange, goes dark after 100 ms without any.
// - Encoder status input is active low; open input reads inactive.
// - Indicators mirror tracks, status, gate and external latch input levels.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "iec_params.svh"

module iec_counter #(
  parameter int unsigned RUN_TIMEOUT_CYC = `IEC_RUN_TIMEOUT_CYC,
  parameter int unsigned CNT_W           = 16,
  parameter int unsigned PER_W           = 24
) (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Encoder tracks, true and inverted.
  input  wire logic        track_a_i,
  input  wire logic        track_a_n_i,
  input  wire logic        track_b_i,
  input  wire logic        track_b_n_i,
  input  wire logic        track_c_i,
  input  wire logic        track_c_n_i,
  // Encoder alarm and field inputs.
  input  wire logic        encoder_status_n_i,
  input  wire logic        counter_hold_gate_input_i,
  input  wire logic        external_latch_input_i,
  // Indicators.
  output logic             led_a_o,
  output logic             led_b_o,
  output logic             led_c_o,
  output logic             led_status_o,
  output logic             led_gate_o,
  output logic             led_latch_o,
  output logic             led_run_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NIN = 9;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1;
  logic [NIN-1:0] sync2;
  // Reset values match idle pin levels, so an open alarm pin reads inactive after reset.
  localparam logic [NIN-1:0] SYNC_IDLE = 9'h040;

  // Field pins gathered for one synchroniser per bit.
  assign raw_in = {external_latch_input_i, counter_hold_gate_input_i, encoder_status_n_i,
                   track_c_n_i, track_c_i, track_b_n_i, track_b_i, track_a_n_i, track_a_i};

  // Two flip-flops per pin; only the second stage is read by logic.
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1[gi] <= SYNC_IDLE[gi];
          sync2[gi] <= SYNC_IDLE[gi];
        end else begin
          sync1[gi] <= raw_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]       ctrl_byte;
  logic [15:0]      preset_word;
  logic [23:0]      out_hi;
  logic [4:0]       feature;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] latch_word;
  logic [PER_W-1:0] period_run;
  logic [PER_W-1:0] period_word;
  logic [3:0]       tick_div;
  logic             latch_valid;
  logic             overflow;
  logic             underflow;
  logic             period_valid;
  logic             seen_a_edge;
  logic             a_q;
  logic             b_q;
  logic             c_q;
  logic             ext_q;
  logic [31:0]      run_cnt;

  // ----------------------------------------------------------------
  // Track conditioning
  // ----------------------------------------------------------------
  wire            compl_mode = feature[`IEC_FEA_COMPL];
  iec_pkg::iec_mode_t mode;
  iec_pkg::iec_eval_t eval;
  wire            a_lvl;
  wire            b_lvl;
  wire            c_lvl;
  wire            gate_lvl   = sync2[7];
  wire            ext_lvl    = sync2[8];
  wire            alarm      = ~sync2[6];

  // Complementary form needs the inverted line low as well.
  assign mode  = iec_pkg::iec_mode_t'(feature[`IEC_FEA_MODE_LSB +: 2]);
  assign eval  = iec_pkg::iec_eval_t'(feature[`IEC_FEA_EVAL_LSB +: 2]);
  assign a_lvl = compl_mode ? (sync2[0] & ~sync2[1]) : sync2[0];
  assign b_lvl = compl_mode ? (sync2[2] & ~sync2[3]) : sync2[2];
  assign c_lvl = compl_mode ? (sync2[4] & ~sync2[5]) : sync2[4];

  // ----------------------------------------------------------------
  // Edge detection and step decode
  // ----------------------------------------------------------------
  wire a_rise   = a_lvl & ~a_q;
  wire a_edge   = a_lvl ^ a_q;
  wire b_edge   = b_lvl ^ b_q;
  wire c_rise   = c_lvl & ~c_q;
  wire ext_rise = ext_lvl & ~ext_q;
  wire quad_dir = a_lvl ^ b_q;
  logic quad_step;
  logic step;
  logic step_up;

  // Step qualifier for each evaluation and mode.
  always_comb begin
    unique case (eval)
      iec_pkg::IEC_EVAL_X1: quad_step = a_rise;
      iec_pkg::IEC_EVAL_X2: quad_step = a_edge;
      iec_pkg::IEC_EVAL_X4: quad_step = a_edge | b_edge;
      default:              quad_step = a_edge | b_edge;
    endcase
    if (mode == iec_pkg::IEC_MODE_UPDOWN) begin
      step    = a_rise & ~c_lvl;
      step_up = ~b_lvl;
    end else begin
      step    = quad_step;
      step_up = quad_dir;
    end
  end

  wire count_en = step & ~gate_lvl;
  wire at_max   = (counter == {CNT_W{1'b1}});
  wire at_min   = (counter == {CNT_W{1'b0}});
  wire wrap_up  = count_en & step_up & at_max;
  wire wrap_dn  = count_en & ~step_up & at_min;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup_ph  = psel_i & ~penable_i;
  wire access_ph = psel_i & penable_i & pready_o;
  wire wr_en     = access_ph & pwrite_i;
  wire sel_outlo = (paddr_i == `IEC_OFF_OUT_LO);
  wire sel_outhi = (paddr_i == `IEC_OFF_OUT_HI);
  wire sel_inlo  = (paddr_i == `IEC_OFF_IN_LO);
  wire sel_inhi  = (paddr_i == `IEC_OFF_IN_HI);
  wire sel_fea   = (paddr_i == `IEC_OFF_FEATURE);
  wire sel_st    = (paddr_i == `IEC_OFF_STATUS);
  wire mapped    = sel_outlo | sel_outhi | sel_inlo | sel_inhi | sel_fea | sel_st;
  wire preset_wr = wr_en & sel_outlo & pwdata_i[`IEC_CTL_SET_COUNTER];
  wire st_wr     = wr_en & sel_st;
  wire per_mode  = (mode == iec_pkg::IEC_MODE_PERIOD);

  // Input image: status byte, counter COUNTER_WORD_BYTES, then D2 and LATCH_WORD_BYTES.
  wire [7:0]  status_byte = {2'h0, gate_lvl, alarm, period_valid, underflow, overflow, latch_valid};
  wire [7:0]  d2_byte     = per_mode ? period_word[23:16] : 8'h00;
  wire [15:0] d34_word    = per_mode ? period_word[15:0] : latch_word;
  wire [31:0] in_lo       = {d2_byte, counter, status_byte};
  wire [31:0] in_hi       = {16'h0000, d34_word};
  logic [31:0] rd_mux;

  // Read data selection.
  assign rd_mux = sel_outlo ? {8'h00, preset_word, ctrl_byte} :
                  sel_outhi ? {8'h00, out_hi} :
                  sel_inlo  ? in_lo :
                  sel_inhi  ? in_hi :
                  sel_fea   ? {27'h0, feature} :
                  sel_st    ? {24'h0, status_byte} : 32'h0000_0000;

  // One wait-free access cycle: ready and read data load in setup.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph & ~mapped;
      prdata_o  <= (setup_ph & ~pwrite_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // Output image and feature setting; the set bit acts only once.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_byte   <= 8'h00;
      preset_word <= 16'h0000;
      out_hi      <= 24'h00_0000;
      feature     <= `IEC_FEATURE_RST;
    end else begin
      if (wr_en & sel_outlo) begin
        ctrl_byte   <= pwdata_i[7:0] & ~(8'h01 << `IEC_CTL_SET_COUNTER);
        preset_word <= pwdata_i[23:8];
      end
      if (wr_en & sel_outhi) begin
        out_hi <= pwdata_i[23:0];
      end
      if (wr_en & sel_fea) begin
        feature <= pwdata_i[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter and latch
  // ----------------------------------------------------------------
  wire zp_latch  = c_rise & ctrl_byte[`IEC_CTL_ZP_LATCH_EN] & (mode != iec_pkg::IEC_MODE_UPDOWN);
  wire ext_latch = ext_rise & ctrl_byte[`IEC_CTL_EXT_LATCH_EN];
  wire do_latch  = zp_latch | ext_latch;

  // Edge history for the detectors.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_q   <= 1'b0;
      b_q   <= 1'b0;
      c_q   <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      a_q   <= a_lvl;
      b_q   <= b_lvl;
      c_q   <= c_lvl;
      ext_q <= ext_lvl;
    end
  end

  // Preset wins over counting; wrap is natural modulo arithmetic.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      counter <= {CNT_W{1'b0}};
    end else if (preset_wr) begin
      counter <= CNT_W'(pwdata_i[23:8]);
    end else if (count_en) begin
      counter <= step_up ? counter + 1'b1 : counter - 1'b1;
    end
  end

  // Latch capture from index or external input.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_word <= {CNT_W{1'b0}};
    end else if (do_latch) begin
      latch_word <= counter;
    end
  end

  // Sticky flags; a new event beats a write-one clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_valid  <= 1'b0;
      overflow     <= 1'b0;
      underflow    <= 1'b0;
    end else begin
      latch_valid <= do_latch | (latch_valid & ~(st_wr & pwdata_i[`IEC_ST_LATCH_VALID]));
      overflow    <= wrap_up | (overflow & ~(st_wr & pwdata_i[`IEC_ST_OVERFLOW]));
      underflow   <= wrap_dn | (underflow & ~(st_wr & pwdata_i[`IEC_ST_UNDERFLOW]));
    end
  end

  // ----------------------------------------------------------------
  // Period measurement
  // ----------------------------------------------------------------
  wire tick    = (tick_div == 4'(`IEC_PERIOD_TICK_CYC - 1));
  wire per_cap = per_mode & a_rise & seen_a_edge;
  wire per_sat = (period_run == {PER_W{1'b1}});

  // Prescaler to the 200 ns resolution, restarted on each A rise.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_div <= 4'h0;
    end else if (a_rise | tick) begin
      tick_div <= 4'h0;
    end else begin
      tick_div <= tick_div + 4'h1;
    end
  end

  // Running count between rising A edges, saturating when too slow.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      period_run   <= {PER_W{1'b0}};
      period_word  <= {PER_W{1'b0}};
      seen_a_edge  <= 1'b0;
      period_valid <= 1'b0;
    end else begin
      if (!per_mode) begin
        period_run  <= {PER_W{1'b0}};
        seen_a_edge <= 1'b0;
      end else if (a_rise) begin
        period_run  <= {PER_W{1'b0}};
        seen_a_edge <= 1'b1;
      end else if (tick & ~per_sat) begin
        period_run  <= period_run + 1'b1;
      end
      if (per_cap) begin
        period_word <= period_run + PER_W'(tick & ~per_sat);
      end
      period_valid <= per_cap | (period_valid & ~(st_wr & pwdata_i[`IEC_ST_PERIOD_VALID]));
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  wire run_alive = (run_cnt != 32'h0000_0000);

  // Any completed bus access counts as process data exchange.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_cnt <= 32'h0000_0000;
    end else if (access_ph) begin
      run_cnt <= 32'(RUN_TIMEOUT_CYC);
    end else if (run_alive) begin
      run_cnt <= run_cnt - 32'h0000_0001;
    end
  end

  // Indicator flops follow the synchronised levels; the run flop follows the run timer.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_a_o      <= 1'b0;
      led_b_o      <= 1'b0;
      led_c_o      <= 1'b0;
      led_status_o <= 1'b0;
      led_gate_o   <= 1'b0;
      led_latch_o  <= 1'b0;
      led_run_o    <= 1'b0;
    end else begin
      led_a_o      <= a_lvl;
      led_b_o      <= b_lvl;
      led_c_o      <= c_lvl;
      led_status_o <= alarm;
      led_gate_o   <= gate_lvl;
      led_latch_o  <= ext_lvl;
      led_run_o    <= run_alive;
    end
  end

endmodule // iec_counter

//--- test/iec_counter_props.sv
// Checker of the encoder counter bus handshake and indicator outputs.
`timescale 1ns/1ns

module iec_counter_props #(
  parameter int unsigned RUN_TIMEOUT_CYC = 50
) (
  // Clock and reset.
  input wire logic        core_clk_i,
  input wire logic        rstn_i,
  // APB slave side.
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Field inputs and indicators.
  input wire logic        encoder_status_n_i,
  input wire logic        counter_hold_gate_input_i,
  input wire logic        external_latch_input_i,
  input wire logic        led_status_o,
  input wire logic        led_gate_o,
  input wire logic        led_latch_o,
  input wire logic        led_run_o
);
  int unsigned idle_cnt;

  // Counts cycles since the last completed access; saturates to stay small.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_cnt <= 0;
    end else if (pready_o) begin
      idle_cnt <= 0;
    end else if (idle_cnt < RUN_TIMEOUT_CYC + 8) begin
      idle_cnt <= idle_cnt + 1;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_ready_after_setup;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer after setup");
  property p_ready_cause;
    pready_o |-> $past(psel_i && !penable_i) && psel_i && penable_i;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("answer without request");
  property p_ready_single;
    pready_o |=> !pready_o;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("answer longer than one cycle");
  property p_err_unmapped;
    psel_i && !penable_i && (paddr_i > 8'h14) |=> pslverr_o && pready_o && (prdata_o == 32'h0);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_rdata_idle;
    !pready_o |-> (prdata_o == 32'h0) && !pslverr_o;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_gate_led;
    counter_hold_gate_input_i [*6] |-> led_gate_o;
  endproperty
  a_gate_led: assert property (p_gate_led) else $error("gate indicator wrong");
  property p_latch_led;
    !external_latch_input_i [*6] |-> !led_latch_o;
  endproperty
  a_latch_led: assert property (p_latch_led) else $error("latch indicator wrong");
  property p_alarm_led;
    !encoder_status_n_i [*6] |-> led_status_o;
  endproperty
  a_alarm_led: assert property (p_alarm_led) else $error("alarm indicator wrong");
  property p_run_on;
    pready_o |-> ##[1:2] led_run_o;
  endproperty
  a_run_on: assert property (p_run_on) else $error("run indicator not lit");
  property p_run_off;
    idle_cnt > RUN_TIMEOUT_CYC + 2 |-> !led_run_o;
  endproperty
  a_run_off: assert property (p_run_off) else $error("run indicator not dark");
endmodule // iec_counter_props

bind iec_counter iec_counter_props #(.RUN_TIMEOUT_CYC(RUN_TIMEOUT_CYC)) i_iec_counter_props (
  .core_clk_i, .rstn_i, .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .encoder_status_n_i, .counter_hold_gate_input_i, .external_latch_input_i,
  .led_status_o, .led_gate_o, .led_latch_o, .led_run_o);

//--- test/iec_encoder_model.sv
// Encoder model driving true and inverted quadrature and index tracks.
`timescale 1ns/1ns

module iec_encoder_model (
  // Clock that paces track changes.
  input wire logic core_clk_i,
  // Encoder tracks, true and inverted.
  output logic     track_a_o,
  output logic     track_a_n_o,
  output logic     track_b_o,
  output logic     track_b_n_o,
  output logic     track_c_o,
  output logic     track_c_n_o
);
  logic a = 1'b0;
  logic b = 1'b0;
  logic c = 1'b0;

  // Inverted tracks are true complements, as a line driver makes them.
  assign track_a_o   = a;
  assign track_a_n_o = ~a;
  assign track_b_o   = b;
  assign track_b_n_o = ~b;
  assign track_c_o   = c;
  assign track_c_n_o = ~c;

  // Sets the tracks and holds them three clocks, above the minimum pulse.
  task automatic drive(input logic na, input logic nb, input logic nc);
    @(posedge core_clk_i);
    a <= na;
    b <= nb;
    c <= nc;
    repeat (2) @(posedge core_clk_i);
  endtask

  // Steps the shaft n gray-code states, one track changing per step.
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      if ((a == b) == up) drive(~a, b, c);
      else drive(a, ~b, c);
    end
  endtask
endmodule // iec_encoder_model

//--- test/iec_counter_tb_top.sv
// Self-checking testbench of the encoder counter.
`timescale 1ns/1ns
`include "iec_params.svh"

module iec_counter_tb_top;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic        encoder_status_n_i = 1'b1;
  logic        counter_hold_gate_input_i = 1'b0;
  logic        external_latch_input_i = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  logic        track_a_i, track_a_n_i, track_b_i, track_b_n_i, track_c_i, track_c_n_i;
  logic        led_a_o, led_b_o, led_c_o, led_status_o, led_gate_o, led_latch_o, led_run_o;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n, m, k;

  iec_counter #(.RUN_TIMEOUT_CYC(50)) i_iec_counter (
    .core_clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .track_a_i, .track_a_n_i, .track_b_i, .track_b_n_i, .track_c_i,
    .track_c_n_i, .encoder_status_n_i, .counter_hold_gate_input_i, .external_latch_input_i,
    .led_a_o, .led_b_o, .led_c_o, .led_status_o, .led_gate_o, .led_latch_o, .led_run_o);

  iec_encoder_model i_iec_encoder_model (
    .core_clk_i, .track_a_o(track_a_i), .track_a_n_o(track_a_n_i), .track_b_o(track_b_i),
    .track_b_n_o(track_b_n_i), .track_c_o(track_c_i), .track_c_n_o(track_c_n_i));

  // Makes the 50 MHz clock.
  always #10 core_clk_i = ~core_clk_i;

  // Cuts a hung run short.
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge core_clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask

  // One APB transfer: setup, then access held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] mk, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd & mk);
  endtask

  // Count a fold setting yields for whole quadrature cycles.
  function automatic logic [31:0] fold_cnt(input int e, input int trans);
    return 32'((trans / 4) << e) << 8;
  endfunction

  // Counter field of the input word for a signed position.
  function automatic logic [31:0] cw(input int v);
    return {8'h00, 16'(v), 8'h00};
  endfunction

  // Main sequence.
  initial begin
    n = $urandom(76178);
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rdchk("feature", `IEC_OFF_FEATURE, 32'hFFFFFFFF, 32'h18);
    rdchk("status", `IEC_OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    for (int e = 0; e < 3; e++) begin
      for (int cm = 0; cm < 2; cm++) begin
        apb(1'b1, `IEC_OFF_FEATURE, {27'h0, 1'(cm), 2'(e), 2'h0});
        apb(1'b1, `IEC_OFF_OUT_LO, 32'h04);
        i_iec_encoder_model.quad(16, 1'b1);
        wt(4);
        rdchk("fold", `IEC_OFF_IN_LO, 32'h00FFFF00, fold_cnt(e, 16));
      end
    end
    apb(1'b1, `IEC_OFF_FEATURE, 32'h18);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h04);
    n = $urandom_range(5, 40);
    m = $urandom_range(1, n);
    i_iec_encoder_model.quad(n, 1'b1);
    i_iec_encoder_model.quad(m, 1'b0);
    wt(4);
    rdchk("updown", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(n - m));
    i_iec_encoder_model.quad(n - m + 2, 1'b0);
    wt(4);
    rdchk("wrap down", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(-2));
    rdchk("underflow", `IEC_OFF_STATUS, 32'h06, 32'h04);
    apb(1'b1, `IEC_OFF_STATUS, 32'h0F);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h00FFFE04);
    i_iec_encoder_model.quad(3, 1'b1);
    wt(4);
    rdchk("wrap up", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(1));
    rdchk("overflow", `IEC_OFF_STATUS, 32'h06, 32'h02);
    counter_hold_gate_input_i <= 1'b1;
    encoder_status_n_i <= 1'b0;
    wt(6);
    i_iec_encoder_model.quad(5, 1'b1);
    wt(4);
    rdchk("gated", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(1));
    rdchk("live bits", `IEC_OFF_STATUS, 32'h30, 32'h30);
    chk("gate led", 32'h1, 32'(led_gate_o));
    chk("alarm led", 32'h1, 32'(led_status_o));
    counter_hold_gate_input_i <= 1'b0;
    encoder_status_n_i <= 1'b1;
    apb(1'b1, `IEC_OFF_FEATURE, 32'h19);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h00006404);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    repeat (3) begin
      i_iec_encoder_model.drive(1'b1, 1'b0, 1'b0);
      i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    end
    rdchk("count up", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(103));
    i_iec_encoder_model.drive(1'b0, 1'b1, 1'b0);
    repeat (2) begin
      i_iec_encoder_model.drive(1'b1, 1'b1, 1'b0);
      i_iec_encoder_model.drive(1'b0, 1'b1, 1'b0);
    end
    rdchk("count down", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(101));
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b1);
    repeat (2) begin
      i_iec_encoder_model.drive(1'b1, 1'b0, 1'b1);
      i_iec_encoder_model.drive(1'b0, 1'b0, 1'b1);
    end
    chk("c led", 32'h1, 32'(led_c_o));
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    rdchk("locked", `IEC_OFF_IN_LO, 32'h00FFFF00, cw(101));
    apb(1'b1, `IEC_OFF_FEATURE, 32'h18);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h00123405);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b1);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    wt(4);
    rdchk("index latch", `IEC_OFF_IN_HI, 32'hFFFF, 32'h1234);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h00077704);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b1);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    wt(4);
    rdchk("latch off", `IEC_OFF_IN_HI, 32'hFFFF, 32'h1234);
    apb(1'b1, `IEC_OFF_OUT_LO, 32'h02);
    external_latch_input_i <= 1'b1;
    wt(6);
    chk("latch led", 32'h1, 32'(led_latch_o));
    external_latch_input_i <= 1'b0;
    rdchk("ext latch", `IEC_OFF_IN_HI, 32'hFFFF, 32'h0777);
    apb(1'b1, `IEC_OFF_FEATURE, 32'h1A);
    k = $urandom_range(5, 30);
    i_iec_encoder_model.drive(1'b1, 1'b0, 1'b0);
    i_iec_encoder_model.drive(1'b0, 1'b0, 1'b0);
    wt(10 * k - 6);
    i_iec_encoder_model.drive(1'b1, 1'b0, 1'b0);
    wt(4);
    chk("a led", 32'h1, 32'(led_a_o));
    chk("b led", 32'h0, 32'(led_b_o));
    rdchk("period", `IEC_OFF_IN_HI, 32'hFFFF, 32'(k) & 32'hFFFF);
    rdchk("period hi", `IEC_OFF_IN_LO, 32'hFF000000, (32'(k) >> 16) << 24);
    rdchk("period valid", `IEC_OFF_STATUS, 32'h08, 32'h08);
    apb(1'b1, `IEC_OFF_OUT_HI, 32'h00ABCDEF);
    rdchk("out hi", `IEC_OFF_OUT_HI, 32'hFFFFFFFF, 32'h00ABCDEF);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("run led", 32'h1, 32'(led_run_o));
    wt(60);
    chk("run dark", 32'h0, 32'(led_run_o));
    end_sim();
  end
endmodule // iec_counter_tb_top
